/* hw/clock_generator_control.sv */
// clock generator control: registers, reset wait, divider, source control
// ----------------------------------------
// ----------------------------------------
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module clock_generator_control
#(
	parameter int RESET_CYCLES = clkgen_pkg::RESET_PROC_CYCLES
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [clkgen_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] boot_option,
	input wire logic hoco_tick,
	input wire logic main_tick,
	input wire logic sub_tick,
	output clkgen_pkg::osc_ctl_t osc_ctl,
	output logic cpu_start,
	output logic cpu_clk_tick,
	output clkgen_pkg::src_t cpu_clk_source
);
	localparam int RW = $clog2(RESET_CYCLES + 1);
	// option byte bits above the frequency code always read as ones
	localparam logic [4:0] OPT_FILL = 5'h1F;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [RW-1:0] rst_cnt;
		logic started;
		logic opt_taken;
		logic [2:0] opt;
		logic [2:0] div;
		logic [2:0] act_shift;
		clkgen_pkg::div_st_t dv_st;
		logic [1:0] dv_cnt;
		logic [3:0] pre;
		logic [7:0] clock_mode_control;
		logic cmc_done;
		logic [2:0] stabilization_time_select;
		logic [7:0] clock_status_control;
		logic main_clock_select;
		logic subsystem_select;
		logic [31:0] prdata;
		logic pslverr;
		clkgen_pkg::osc_ctl_t osc;
	} st_t;
	st_t s_r;
	st_t s_nxt;

	logic [7:0] stabilization_counter_status;
	logic sw_tick;
	clkgen_pkg::src_t active;
	clkgen_pkg::src_t req;
	logic hoco_run;
	logic hdiv_tick;
	logic hoco_out;
	logic main_run;
	logic main_ext;
	logic setup;
	logic wr;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic hit_any;

	function automatic logic hit(input logic [clkgen_pkg::AW-1:0] a,
		input logic [clkgen_pkg::AW-1:0] idx);
		hit = a == clkgen_pkg::reg_addr(idx);
	endfunction

	function automatic logic [3:0] div_mask(input logic [2:0] sh);
		div_mask = 4'((5'h01 << sh) - 5'h01);
	endfunction

	// ----------------------------------------
	// oscillator status
	// ----------------------------------------
	// stopping the internal clock while selected stalls the cpu clock
	assign hoco_run = !s_r.clock_status_control[clkgen_pkg::CSC_HSTOP];
	assign main_run = s_r.clock_mode_control[clkgen_pkg::CMC_SEL] && !s_r.clock_status_control[clkgen_pkg::CSC_MAIN_OSC_STOP];
	assign main_ext = s_r.clock_mode_control[clkgen_pkg::CMC_EXT];
	assign hdiv_tick = hoco_run && hoco_tick && s_r.pre == div_mask(s_r.act_shift);
	// no ticks leave the divider while it waits on the new frequency
	assign hoco_out = hdiv_tick && s_r.dv_st != clkgen_pkg::DV_WAIT;
	assign req = s_r.subsystem_select ? clkgen_pkg::SRC_SUB
		: (s_r.main_clock_select ? clkgen_pkg::SRC_MAIN : clkgen_pkg::SRC_HOCO);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign wbyte = pwdata[7:0];
	assign hit_any = hit(paddr, clkgen_pkg::OPT_IDX) || hit(paddr, clkgen_pkg::DIV_IDX)
		|| hit(paddr, clkgen_pkg::CMC_IDX) || hit(paddr, clkgen_pkg::STABILIZATION_TIME_SELECT_IDX)
		|| hit(paddr, clkgen_pkg::CSC_IDX) || hit(paddr, clkgen_pkg::STABILIZATION_COUNTER_STATUS_IDX)
		|| hit(paddr, clkgen_pkg::CKC_IDX);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb
	begin
		rbyte = 8'h00;
		if (hit(paddr, clkgen_pkg::OPT_IDX))
			rbyte = {OPT_FILL, s_r.opt};
		else if (hit(paddr, clkgen_pkg::DIV_IDX))
			rbyte = {5'h00, s_r.div};
		else if (hit(paddr, clkgen_pkg::CMC_IDX))
			rbyte = s_r.clock_mode_control;
		else if (hit(paddr, clkgen_pkg::STABILIZATION_TIME_SELECT_IDX))
			rbyte = {5'h00, s_r.stabilization_time_select};
		else if (hit(paddr, clkgen_pkg::CSC_IDX))
			rbyte = s_r.clock_status_control;
		else if (hit(paddr, clkgen_pkg::STABILIZATION_COUNTER_STATUS_IDX))
			rbyte = stabilization_counter_status;
		else if (hit(paddr, clkgen_pkg::CKC_IDX))
		begin
			rbyte[clkgen_pkg::CKC_CLS] = active == clkgen_pkg::SRC_SUB;
			rbyte[clkgen_pkg::CKC_CSS] = s_r.subsystem_select;
			rbyte[clkgen_pkg::CKC_MCS] = active == clkgen_pkg::SRC_MAIN;
			rbyte[clkgen_pkg::CKC_MAIN_CLOCK_SELECT] = s_r.main_clock_select;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		s_nxt = s_r;

		// reset processing wait before the cpu runs
		if (!s_r.started)
		begin
			if (s_r.rst_cnt == RW'(RESET_CYCLES - 1))
				s_nxt.started = 1'b1;
			else
				s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
		end

		// boot strap caught on the first edge after release
		if (!s_r.opt_taken)
		begin
			s_nxt.opt_taken = 1'b1;
			s_nxt.opt = boot_option[2:0];
			s_nxt.div = boot_option[2:0];
			s_nxt.act_shift = clkgen_pkg::freq_shift(boot_option[2:0]);
		end

		// internal oscillator prescaler
		if (hoco_run && hoco_tick)
			s_nxt.pre = hdiv_tick ? 4'h0 : s_r.pre + 4'h1;

		// frequency transition
		unique case (s_r.dv_st)
			clkgen_pkg::DV_OLD:
			begin
				if (hdiv_tick)
				begin
					if (s_r.dv_cnt == clkgen_pkg::TRANS_CLKS - 2'h1)
					begin
						s_nxt.dv_st = clkgen_pkg::DV_WAIT;
						s_nxt.dv_cnt = 2'h0;
						s_nxt.pre = 4'h0;
						s_nxt.act_shift = clkgen_pkg::freq_shift(s_r.div);
					end
					else
						s_nxt.dv_cnt = s_r.dv_cnt + 2'h1;
				end
			end
			clkgen_pkg::DV_WAIT:
			begin
				if (hdiv_tick)
				begin
					if (s_r.dv_cnt == clkgen_pkg::TRANS_CLKS - 2'h1)
						s_nxt.dv_st = clkgen_pkg::DV_RUN;
					else
						s_nxt.dv_cnt = s_r.dv_cnt + 2'h1;
				end
			end
			default:
				s_nxt.dv_cnt = 2'h0;
		endcase

		// register writes take effect in the access phase
		// a divider write mid-transition restarts it at the present rate
		if (wr && hit(paddr, clkgen_pkg::DIV_IDX))
		begin
			// prohibited codes leave the frequency alone
			if (wbyte[2:0] >= clkgen_pkg::FREQ_MIN && wbyte[2:0] <= clkgen_pkg::FREQ_MAX)
			begin
				s_nxt.div = wbyte[2:0];
				s_nxt.dv_st = clkgen_pkg::DV_OLD;
				s_nxt.dv_cnt = 2'h0;
			end
		end
		// mode register locks after its first byte-wide write
		if (wr && hit(paddr, clkgen_pkg::CMC_IDX) && !s_r.cmc_done
			&& pstrb == clkgen_pkg::BYTE0_STRB)
		begin
			s_nxt.clock_mode_control = wbyte;
			s_nxt.cmc_done = 1'b1;
		end
		// writes to option and counter status are dropped without an error
		if (wr && hit(paddr, clkgen_pkg::STABILIZATION_TIME_SELECT_IDX))
			s_nxt.stabilization_time_select = wbyte[2:0];
		if (wr && hit(paddr, clkgen_pkg::CSC_IDX))
		begin
			s_nxt.clock_status_control = 8'h00;
			s_nxt.clock_status_control[clkgen_pkg::CSC_MAIN_OSC_STOP] = wbyte[clkgen_pkg::CSC_MAIN_OSC_STOP];
			s_nxt.clock_status_control[clkgen_pkg::CSC_XSTOP] = wbyte[clkgen_pkg::CSC_XSTOP];
			s_nxt.clock_status_control[clkgen_pkg::CSC_HSTOP] = wbyte[clkgen_pkg::CSC_HSTOP];
		end
		if (wr && hit(paddr, clkgen_pkg::CKC_IDX))
		begin
			s_nxt.subsystem_select = wbyte[clkgen_pkg::CKC_CSS];
			s_nxt.main_clock_select = wbyte[clkgen_pkg::CKC_MAIN_CLOCK_SELECT];
		end

		// read data is set up ahead of the access phase
		if (setup)
		begin
			s_nxt.prdata = {24'h000000, pwrite ? 8'h00 : rbyte};
			s_nxt.pslverr = !hit_any;
		end

		// oscillator enables from the mode and stop bits
		s_nxt.osc.hoco_en = !s_nxt.clock_status_control[clkgen_pkg::CSC_HSTOP];
		s_nxt.osc.main_osc_en = s_nxt.clock_mode_control[clkgen_pkg::CMC_SEL]
			&& !s_nxt.clock_mode_control[clkgen_pkg::CMC_EXT]
			&& !s_nxt.clock_status_control[clkgen_pkg::CSC_MAIN_OSC_STOP];
		s_nxt.osc.main_ext_en = s_nxt.clock_mode_control[clkgen_pkg::CMC_SEL]
			&& s_nxt.clock_mode_control[clkgen_pkg::CMC_EXT]
			&& !s_nxt.clock_status_control[clkgen_pkg::CSC_MAIN_OSC_STOP];
		s_nxt.osc.main_gain = s_nxt.clock_mode_control[clkgen_pkg::CMC_GAIN];
		s_nxt.osc.sub_osc_en = s_nxt.clock_mode_control[clkgen_pkg::CMC_SSEL]
			&& !s_nxt.clock_mode_control[clkgen_pkg::CMC_SEXT]
			&& !s_nxt.clock_status_control[clkgen_pkg::CSC_XSTOP];
		s_nxt.osc.sub_ext_en = s_nxt.clock_mode_control[clkgen_pkg::CMC_SSEL]
			&& s_nxt.clock_mode_control[clkgen_pkg::CMC_SEXT]
			&& !s_nxt.clock_status_control[clkgen_pkg::CSC_XSTOP];
		s_nxt.osc.sub_pin = s_nxt.clock_mode_control[clkgen_pkg::CMC_SUB_PIN_SELECT];
		s_nxt.osc.sub_mode = {s_nxt.clock_mode_control[clkgen_pkg::CMC_SMODE_HI],
			s_nxt.clock_mode_control[clkgen_pkg::CMC_SMODE_LO]};
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.dv_st <= clkgen_pkg::DV_RUN;
			s_r.clock_mode_control <= clkgen_pkg::CMC_RST;
			s_r.stabilization_time_select <= clkgen_pkg::STABILIZATION_TIME_SELECT_RST;
			s_r.clock_status_control <= clkgen_pkg::CSC_RST;
			s_r.osc.hoco_en <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------
	// stabilization counter and source switch
	// ----------------------------------------
	// ready flag is spare: no stop-mode release here, software polls the flags
	stab_counter u_stab
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(main_run),
		.ext(main_ext),
		.tick(main_tick),
		.stabilization_time_select(s_r.stabilization_time_select),
		.status(stabilization_counter_status),
		.ready()
	);

	// switching does not wait on the stabilization flag; software polls it
	clock_switch u_switch
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(s_r.started),
		.req(req),
		.tick_hoco(hoco_out),
		.tick_main(main_tick),
		.tick_sub(sub_tick),
		.clk_tick(sw_tick),
		.active(active)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr && psel && penable;
	// no wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	assign osc_ctl = s_r.osc;
	assign cpu_start = s_r.started;
	assign cpu_clk_tick = sw_tick;
	assign cpu_clk_source = active;
endmodule
`default_nettype wire

/* hw/clkgen_pkg.sv */
// shared constants, types and helpers of the clock generator control
package clkgen_pkg;

	// ----------------------------------------
	// register map (index, byte address = 4 * index)
	// ----------------------------------------
	localparam int AW = 24;
	localparam logic [AW-1:0] OPT_IDX = 24'h0000C2;
	localparam logic [AW-1:0] DIV_IDX = 24'h0F00A8;
	localparam logic [AW-1:0] CMC_IDX = 24'h000010;
	localparam logic [AW-1:0] STABILIZATION_TIME_SELECT_IDX = 24'h000011;
	localparam logic [AW-1:0] CSC_IDX = 24'h000012;
	localparam logic [AW-1:0] STABILIZATION_COUNTER_STATUS_IDX = 24'h000013;
	localparam logic [AW-1:0] CKC_IDX = 24'h000014;

	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [7:0] CMC_RST = 8'h00;
	localparam logic [2:0] STABILIZATION_TIME_SELECT_RST = 3'h7;
	localparam logic [7:0] CSC_RST = 8'hC0;
	localparam logic [3:0] BYTE0_STRB = 4'h1;
	localparam int CMC_EXT = 7;
	localparam int CMC_SEL = 6;
	localparam int CMC_SEXT = 5;
	localparam int CMC_SSEL = 4;
	localparam int CMC_SUB_PIN_SELECT = 3;
	localparam int CMC_SMODE_HI = 2;
	localparam int CMC_SMODE_LO = 1;
	localparam int CMC_GAIN = 0;
	localparam int CSC_MAIN_OSC_STOP = 7;
	localparam int CSC_XSTOP = 6;
	localparam int CSC_HSTOP = 0;
	localparam int CKC_CLS = 7;
	localparam int CKC_CSS = 6;
	localparam int CKC_MCS = 5;
	localparam int CKC_MAIN_CLOCK_SELECT = 4;
	localparam logic [2:0] FREQ_MIN = 3'h1;
	localparam logic [2:0] FREQ_MAX = 3'h5;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS = 5;
	localparam int RESET_PROC_NS = 100000;
	localparam int RESET_PROC_CYCLES = (RESET_PROC_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] TRANS_CLKS = 2'h3;
	localparam int STAB_W = 19;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {SRC_HOCO = 2'b00, SRC_MAIN = 2'b01, SRC_SUB = 2'b10} src_t;
	typedef enum logic [1:0] {DV_RUN = 2'b00, DV_OLD = 2'b01, DV_WAIT = 2'b10} div_st_t;
	typedef struct packed {
		logic hoco_en;
		logic main_osc_en;
		logic main_ext_en;
		logic main_gain;
		logic sub_osc_en;
		logic sub_ext_en;
		logic sub_pin;
		logic [1:0] sub_mode;
	} osc_ctl_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [AW-1:0] reg_addr(input logic [AW-1:0] idx);
		reg_addr = {idx[AW-3:0], 2'b00};
	endfunction

	// divide shift of the internal oscillator: 16 MHz base
	function automatic logic [2:0] freq_shift(input logic [2:0] code);
		freq_shift = (code >= FREQ_MIN && code <= FREQ_MAX) ? code - FREQ_MIN : 3'h0;
	endfunction

	// log2 of cycles behind each counter status flag, msb first
	function automatic int stab_exp(input logic [2:0] k);
		case (k)
			3'h0: stab_exp = 8;
			3'h1: stab_exp = 9;
			3'h2: stab_exp = 10;
			3'h3: stab_exp = 11;
			3'h4: stab_exp = 13;
			3'h5: stab_exp = 15;
			3'h6: stab_exp = 17;
			default: stab_exp = 18;
		endcase
	endfunction

endpackage

/* hw/stab_counter.sv */
// main oscillator stabilization counter and its status flags
`timescale 1ns/1ps
`default_nettype none
module stab_counter
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic ext,
	input wire logic tick,
	input wire logic [2:0] stabilization_time_select,
	output logic [7:0] status,
	output logic ready
);
	typedef struct packed {
		logic [clkgen_pkg::STAB_W-1:0] cnt;
		logic [7:0] status;
		logic ready;
	} st_t;
	st_t s_r;
	st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (!run)
			s_nxt.cnt = '0;
		else if (tick && !s_r.cnt[clkgen_pkg::STAB_W-1])
			s_nxt.cnt = s_r.cnt + 1'b1;
		for (int i = 0; i < 8; i++)
			s_nxt.status[7-i] = run && (ext ||
				s_nxt.cnt >= (clkgen_pkg::STAB_W'(1) << clkgen_pkg::stab_exp(3'(i))));
		// external clock needs no wait
		s_nxt.ready = s_nxt.status[3'h7 - stabilization_time_select];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign status = s_r.status;
	assign ready = s_r.ready;
endmodule
`default_nettype wire

/* hw/clock_switch.sv */
// glitch-free selection of the cpu/peripheral clock tick
`timescale 1ns/1ps
`default_nettype none
module clock_switch
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire clkgen_pkg::src_t req,
	input wire logic tick_hoco,
	input wire logic tick_main,
	input wire logic tick_sub,
	output logic clk_tick,
	output clkgen_pkg::src_t active
);
	typedef struct packed {
		clkgen_pkg::src_t cur;
		logic gap;
		logic tick;
	} st_t;
	st_t s_r;
	st_t s_nxt;
	logic sel;

	always_comb
	begin
		s_nxt = s_r;
		unique case (s_r.cur)
			clkgen_pkg::SRC_MAIN: sel = tick_main;
			clkgen_pkg::SRC_SUB: sel = tick_sub;
			default: sel = tick_hoco;
		endcase
		// leave the old source only at the end of a whole period
		if (s_r.gap)
		begin
			s_nxt.cur = req;
			s_nxt.gap = 1'b0;
		end
		else if (s_r.cur != req && sel)
			s_nxt.gap = 1'b1;
		s_nxt.tick = run && sel && !s_r.gap;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.cur <= clkgen_pkg::SRC_HOCO;
		end
		else
			s_r <= s_nxt;
	end

	assign clk_tick = s_r.tick;
	assign active = s_r.cur;
endmodule
`default_nettype wire

/* testbench/clock_generator_control_asserts.sv */
// port assertions of the clock generator control
`timescale 1ns/1ps
`default_nettype none
module clock_generator_control_asserts
#(
	parameter int RESET_CYCLES = 16
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [clkgen_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] boot_option,
	input wire logic hoco_tick,
	input wire logic main_tick,
	input wire logic sub_tick,
	input wire clkgen_pkg::osc_ctl_t osc_ctl,
	input wire logic cpu_start,
	input wire logic cpu_clk_tick,
	input wire clkgen_pkg::src_t cpu_clk_source
);
	int cnt;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// cycles since release, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= 0;
		else if (cnt <= RESET_CYCLES)
			cnt <= cnt + 1;
	end
	a_start_timing: assert property (cpu_start == (cnt >= RESET_CYCLES))
		else $error("cpu start at wrong cycle");
	a_hoco_first: assert property (!cpu_start |-> osc_ctl.hoco_en &&
		cpu_clk_source == clkgen_pkg::SRC_HOCO)
		else $error("internal clock not first");
	a_no_early_tick: assert property (!cpu_start |-> !cpu_clk_tick)
		else $error("tick before start");
	a_main_excl: assert property (!(osc_ctl.main_osc_en && osc_ctl.main_ext_en))
		else $error("main crystal and input both on");
	a_sub_excl: assert property (!(osc_ctl.sub_osc_en && osc_ctl.sub_ext_en))
		else $error("sub crystal and input both on");
	a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_err_access: assert property (pslverr |-> psel && penable && prdata == 32'h0)
		else $error("error outside access");
	a_tick_single: assert property (cpu_clk_tick |=> !cpu_clk_tick)
		else $error("runt tick");
	// settled source: the tick must follow that source's own tick
	a_main_ticks: assert property (cpu_clk_tick && cpu_clk_source == clkgen_pkg::SRC_MAIN &&
		$past(cpu_clk_source, 3) == clkgen_pkg::SRC_MAIN |->
		$past(main_tick) || $past(main_tick, 2) || $past(main_tick, 3))
		else $error("main tick missing");
	a_sub_ticks: assert property (cpu_clk_tick && cpu_clk_source == clkgen_pkg::SRC_SUB &&
		$past(cpu_clk_source, 3) == clkgen_pkg::SRC_SUB |->
		$past(sub_tick) || $past(sub_tick, 2) || $past(sub_tick, 3))
		else $error("sub tick missing");
	c_start: cover property ($rose(cpu_start));
	c_main: cover property (cpu_clk_source == clkgen_pkg::SRC_MAIN);
	c_sub: cover property (cpu_clk_source == clkgen_pkg::SRC_SUB);
endmodule
`default_nettype wire

/* testbench/osc_model.sv */
// oscillator model: tick pulses of the three clock sources
`timescale 1ns/1ps
`default_nettype none
module osc_model
#(
	parameter int HP = 4,
	parameter int MP = 4,
	parameter int SP = 8
)
(
	input wire logic pclk,
	input wire clkgen_pkg::osc_ctl_t osc_ctl,
	output logic hoco_tick,
	output logic main_tick,
	output logic sub_tick
);
	int h = 0;
	int m = 0;
	int s = 0;
	// stopped sources stand still, no ticks
	always @(posedge pclk)
	begin
		h <= osc_ctl.hoco_en ? (h + 1) % HP : 0;
		m <= (osc_ctl.main_osc_en || osc_ctl.main_ext_en) ? (m + 1) % MP : 0;
		s <= (osc_ctl.sub_osc_en || osc_ctl.sub_ext_en) ? (s + 1) % SP : 0;
	end
	assign hoco_tick = osc_ctl.hoco_en && h == HP - 1;
	assign main_tick = m == MP - 1;
	assign sub_tick = s == SP - 1;
endmodule
`default_nettype wire

/* testbench/clock_generator_control_bench.sv */
// self-checking bench of the clock generator control
`timescale 1ns/1ps
`default_nettype none
module clock_generator_control_bench;
	localparam int RC = 16;
	localparam int HP = 4;
	localparam int MP = 4;
	localparam int SP = 8;
	localparam logic [23:0] A_OPT = clkgen_pkg::OPT_IDX << 2;
	localparam logic [23:0] A_DIV = clkgen_pkg::DIV_IDX << 2;
	localparam logic [23:0] A_CMC = clkgen_pkg::CMC_IDX << 2;
	localparam logic [23:0] A_STABILIZATION_TIME_SELECT = clkgen_pkg::STABILIZATION_TIME_SELECT_IDX << 2;
	localparam logic [23:0] A_CSC = clkgen_pkg::CSC_IDX << 2;
	localparam logic [23:0] A_STABILIZATION_COUNTER_STATUS = clkgen_pkg::STABILIZATION_COUNTER_STATUS_IDX << 2;
	localparam logic [23:0] A_CKC = clkgen_pkg::CKC_IDX << 2;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [23:0] paddr = 24'h000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic [7:0] boot_option = 8'hF9;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic hoco_tick;
	logic main_tick;
	logic sub_tick;
	clkgen_pkg::osc_ctl_t osc_ctl;
	logic cpu_start;
	logic cpu_clk_tick;
	clkgen_pkg::src_t cpu_clk_source;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	always #2.5 pclk = ~pclk;
	clock_generator_control #(.RESET_CYCLES(RC)) dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .boot_option(boot_option), .hoco_tick(hoco_tick),
		.main_tick(main_tick), .sub_tick(sub_tick), .osc_ctl(osc_ctl), .cpu_start(cpu_start),
		.cpu_clk_tick(cpu_clk_tick), .cpu_clk_source(cpu_clk_source)
	);
	osc_model #(.HP(HP), .MP(MP), .SP(SP)) osc
	(
		.pclk(pclk), .osc_ctl(osc_ctl), .hoco_tick(hoco_tick), .main_tick(main_tick),
		.sub_tick(sub_tick)
	);
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rng(input string what, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi)
		begin
			err_count++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic apb(input logic w, input logic [23:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, 4'h1, rd, er);
	endtask
	task automatic rdc(input string what, input logic [23:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 8'h00, 4'h0, rd, er);
		chk(what, exp, rd);
	endtask
	task automatic ticks(input int win, output int n);
		n = 0;
		repeat (win)
		begin
			@(posedge pclk);
			#1;
			if (cpu_clk_tick === 1'b1)
				n++;
		end
	endtask
	task automatic wsrc(input clkgen_pkg::src_t s);
		int n;
		n = 0;
		while (cpu_clk_source !== s && n < 64)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("source", s, cpu_clk_source);
	endtask
	task automatic rst(input logic [2:0] code);
		int n;
		presetn <= 1'b0;
		boot_option <= {5'h1F, code};
		repeat (20) @(posedge pclk);
		chk("hoco in reset", 1, osc_ctl.hoco_en);
		presetn <= 1'b1;
		n = 0;
		while (cpu_start !== 1'b1 && n < 100)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("reset wait", RC, n);
		chk("first source", clkgen_pkg::SRC_HOCO, cpu_clk_source);
	endtask
	task automatic stab(output int n);
		logic [31:0] rd;
		logic er;
		time t0;
		t0 = $time;
		rd = 32'h0;
		while (rd[5] !== 1'b1 && $time - t0 < 40000)
		begin
			apb(1'b0, A_STABILIZATION_COUNTER_STATUS, 8'h00, 4'h0, rd, er);
			if (!(rd[7:0] inside {8'h00, 8'h80, 8'hC0, 8'hE0}))
				chk("fill order", 32'hE0, rd);
		end
		chk("counter status", 32'hE0, rd);
		n = int'(($time - t0) / 5);
	endtask
	task automatic t_boot();
		int n;
		for (int c = 1; c <= 5; c++)
		begin
			rst(3'(c));
			rdc("option", A_OPT, 32'hF8 | c);
			ticks(512, n);
			rng("boot rate", (128 >> (c - 1)) - 1, (128 >> (c - 1)) + 1, n);
		end
		rdc("divider", A_DIV, 32'h5);
		rdc("mode", A_CMC, {24'h0, clkgen_pkg::CMC_RST});
		rdc("stab sel", A_STABILIZATION_TIME_SELECT, {29'h0, clkgen_pkg::STABILIZATION_TIME_SELECT_RST});
		rdc("status ctl", A_CSC, {24'h0, clkgen_pkg::CSC_RST});
		rdc("counter", A_STABILIZATION_COUNTER_STATUS, 32'h0);
		rdc("system ctl", A_CKC, 32'h0);
	endtask
	task automatic t_div();
		int tt[8];
		int t;
		int k;
		logic [2:0] cur;
		rst(3'h1);
		wr(A_DIV, 8'hFA);
		t = 0;
		k = 0;
		repeat (100)
		begin
			@(posedge pclk);
			#1;
			t++;
			if (cpu_clk_tick === 1'b1 && k < 8)
			begin
				tt[k] = t;
				k++;
			end
		end
		chk("old gap", HP, tt[2] - tt[1]);
		rng("held gap", 6 * HP, 10 * HP, tt[3] - tt[2]);
		chk("new gap", 2 * HP, tt[5] - tt[4]);
		cur = 3'h2;
		for (int c = 0; c < 8; c++)
		begin
			wr(A_DIV, 8'(c));
			if (c >= 1 && c <= 5)
				cur = 3'(c);
			rdc("divider", A_DIV, {29'h0, cur});
			repeat (80) @(posedge pclk);
		end
	endtask
	task automatic t_main();
		logic [31:0] rd;
		logic er;
		int n;
		rst(3'h1);
		apb(1'b0, 24'h000054, 8'h00, 4'h0, rd, er);
		chk("unmapped error", 1, er);
		chk("unmapped data", 0, rd);
		apb(1'b1, A_CMC, 8'h40, 4'h3, rd, er);
		rdc("wide mode write", A_CMC, 32'h0);
		wr(A_CMC, 8'h40);
		wr(A_CMC, 8'h00);
		rdc("mode", A_CMC, 32'h40);
		chk("main off", 0, osc_ctl.main_osc_en);
		wr(A_STABILIZATION_TIME_SELECT, 8'h02);
		rdc("stab sel", A_STABILIZATION_TIME_SELECT, 32'h2);
		repeat (2)
		begin
			wr(A_CSC, 8'h40);
			stab(n);
			rng("stab time", 1024 * MP, 1024 * MP + 16, n);
			chk("crystal on", 2'b10, {osc_ctl.main_osc_en, osc_ctl.main_ext_en});
			wr(A_CSC, 8'hC0);
			repeat (4) @(posedge pclk);
			rdc("cleared counter", A_STABILIZATION_COUNTER_STATUS, 32'h0);
		end
		wr(A_CSC, 8'h40);
		stab(n);
		wr(A_CKC, 8'h10);
		wsrc(clkgen_pkg::SRC_MAIN);
		rdc("system ctl", A_CKC, 32'h30);
		ticks(256, n);
		rng("main rate", 256 / MP - 1, 256 / MP + 1, n);
	endtask
	task automatic t_ext();
		int n;
		rst(3'h1);
		wr(A_CMC, 8'hFF);
		wr(A_CSC, 8'h00);
		repeat (4) @(posedge pclk);
		rdc("ext counter", A_STABILIZATION_COUNTER_STATUS, 32'hFF);
		chk("ext enables", 4'h5, {osc_ctl.main_osc_en, osc_ctl.main_ext_en,
			osc_ctl.sub_osc_en, osc_ctl.sub_ext_en});
		chk("osc controls", 32'h16F, osc_ctl);
		rdc("mode", A_CMC, 32'hFF);
		wr(A_CKC, 8'h40);
		wsrc(clkgen_pkg::SRC_SUB);
		rdc("system ctl", A_CKC, 32'hC0);
		ticks(512, n);
		rng("sub rate", 512 / SP - 1, 512 / SP + 1, n);
		wr(A_CKC, 8'h10);
		wsrc(clkgen_pkg::SRC_MAIN);
		wr(A_CSC, 8'h01);
		@(posedge pclk);
		chk("hoco stopped", 0, osc_ctl.hoco_en);
	endtask
	initial
	begin
		t_boot();
		t_div();
		t_main();
		t_ext();
		tally_and_finish();
	end
endmodule
bind clock_generator_control clock_generator_control_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .boot_option(boot_option), .hoco_tick(hoco_tick),
	.main_tick(main_tick), .sub_tick(sub_tick), .osc_ctl(osc_ctl), .cpu_start(cpu_start),
	.cpu_clk_tick(cpu_clk_tick), .cpu_clk_source(cpu_clk_source)
);
`default_nettype wire
